//--- core/vsc_map.vh
// strap map: address windows, modifiers, levels and field positions for strap configuration
`ifndef VSC_MAP_VH
`define VSC_MAP_VH
`define VSC_AM_STD 6'h3D
`define VSC_AM_EXT 6'h0D
`define VSC_AM_SHORT 6'h2D
`define VSC_IRQ_DEFAULT 3'h4
`define VSC_BRQ_DEFAULT 2'h3
`define VSC_WIN_MASK 24'hFFFFE0
`define VSC_BASE_0 24'hDFF520
`define VSC_BASE_1 24'hDFF560
`define VSC_BASE_2 24'hDFF580
`define VSC_BASE_3 24'hDFF5C0
`define VSC_BASE_4 24'hDFF620
`define VSC_BASE_5 24'hFFF520
`define VSC_BASE_6 24'hFFF560
`define VSC_BASE_7 24'hFFF580
`define VSC_BASE_8 24'hFFF5A0
`define VSC_BASE_9 24'hFFF5C0
`define VSC_BASE_10 24'h00F520
`define VSC_BASE_11 24'h00F560
`define VSC_ASEL_E11 3
`define VSC_ASEL_E12 2
`define VSC_ASEL_E13 1
`define VSC_ASEL_E14 0
`define VSC_ASEL_E15 4
`define VSC_BAUD_CODES 16
`endif

//--- core/vsc_baud_table.v
// baud table lookup: per-line rate code to rate in baud for the selected table
`timescale 1ns/1ps
module vsc_baud_table (
    input wire table_alt,
    input wire [3:0] rate_code,
    output reg [15:0] rate_baud,
    output reg rate_valid
);
    // half-baud rates (134.5) are reported as 134; zero marks an absent entry
    always @* begin
        rate_baud = 16'h0000;
        if (!table_alt) begin
            case (rate_code)
                4'h0: rate_baud = 16'h004B;
                4'h1: rate_baud = 16'h006E;
                4'h2: rate_baud = 16'h0086;
                4'h3: rate_baud = 16'h0096;
                4'h4: rate_baud = 16'h012C;
                4'h5: rate_baud = 16'h0258;
                4'h6: rate_baud = 16'h04B0;
                4'h7: rate_baud = 16'h0708;
                4'h8: rate_baud = 16'h07D0;
                4'h9: rate_baud = 16'h0960;
                4'hA: rate_baud = 16'h12C0;
                4'hB: rate_baud = 16'h2580;
                4'hC: rate_baud = 16'h4B00;
                default: rate_baud = 16'h0000;
            endcase
        end else begin
            case (rate_code)
                4'h0: rate_baud = 16'h0032;
                4'h1: rate_baud = 16'h006E;
                4'h2: rate_baud = 16'h0086;
                4'h3: rate_baud = 16'h00C8;
                4'h4: rate_baud = 16'h012C;
                4'h5: rate_baud = 16'h0258;
                4'h6: rate_baud = 16'h041A;
                4'h7: rate_baud = 16'h04B0;
                4'h8: rate_baud = 16'h0960;
                4'h9: rate_baud = 16'h12C0;
                4'hA: rate_baud = 16'h1C20;
                4'hB: rate_baud = 16'h2580;
                default: rate_baud = 16'h0000;
            endcase
        end
        rate_valid = (rate_baud != 16'h0000);
    end
endmodule

//--- core/vsc_strap_cfg.v
// strap configuration core: printer mode, interrupt, modifier, baud, slave decode, requester
//
// Overview of operation
// - printer variant from strobe-source and type straps; none fitted gives first variant.
// - interrupt request only on one strap level 3..6; never 1, 2, 7.
// - acknowledge answered only when acknowledged level matches strap code.
// - default straps give level 4 for request and acknowledge.
// - master modifier 3DH by default, 0DH with modifier strap.
// - one global strap picks baud table; default reaches 19200.
// - each line picks rates only from the selected table.
// - 32-byte slave window at one of twelve bases, default FFF520.
// - 24-bit bases need modifier 3DH; 16-bit bases need 2DH.
// - bus request on one strap level 0..3, default 3.
// - requester releases bus once its own transfer completes.
`timescale 1ns/1ps
`include "vsc_map.vh"
module vsc_strap_cfg #(
    parameter LINES = 16
) (
    input wire clk_sys,
    input wire rst_b,
    // straps, high = fitted
    input wire strap_strobe_alt,
    input wire strap_prn_type,
    input wire [2:0] strap_ack_code,
    input wire [3:0] strap_irq_sel,
    input wire strap_am_ext,
    input wire strap_baud_alt,
    input wire [4:0] strap_addr,
    input wire [1:0] strap_brq_sel,
    // slave decode
    input wire [23:0] slv_addr,
    input wire [5:0] slv_am,
    input wire slv_as,
    output reg slv_sel_r,
    // interrupter
    input wire irq_req,
    output reg [7:1] irq_out_r,
    input wire [2:0] iack_level,
    input wire iack_cycle,
    output reg iack_hit_r,
    output reg cfg_err_r,
    // requester
    input wire xfer_req,
    input wire xfer_done,
    input wire bus_grant,
    output reg [3:0] bus_req_r,
    output reg bus_owned_r,
    output reg [5:0] mst_am_r,
    // printer and baud
    output reg prn_alt_r,
    output reg baud_alt_r,
    input wire [4*LINES-1:0] line_rate_code,
    output reg [16*LINES-1:0] line_rate_r,
    output reg [LINES-1:0] line_rate_ok_r
);
    ////////////////////////////////////////////////////////////////
    reg cap_r;
    reg [2:0] irq_lvl_r;
    reg [2:0] ack_code_r;
    reg [23:0] base_r;
    reg short_r;
    reg base_ok_r;
    reg [1:0] brq_lvl_r;
    reg [23:0] base_nxt;
    reg short_nxt;
    reg base_ok_nxt;
    reg [2:0] irq_nxt;

    // one-hot request strap to level; several or none fitted is a fault
    function [2:0] irq_level;
        input [3:0] sel;
        begin
            case (sel)
                4'h1: irq_level = 3'h3;
                4'h2: irq_level = 3'h4;
                4'h4: irq_level = 3'h5;
                4'h8: irq_level = 3'h6;
                default: irq_level = 3'h0;
            endcase
        end
    endfunction

    always @* begin
        base_nxt = `VSC_BASE_5;
        short_nxt = 1'b0;
        base_ok_nxt = 1'b1;
        // order: E15 E11 E12 E13 E14
        case ({strap_addr[`VSC_ASEL_E15], strap_addr[`VSC_ASEL_E11],
               strap_addr[`VSC_ASEL_E12], strap_addr[`VSC_ASEL_E13],
               strap_addr[`VSC_ASEL_E14]})
            5'h01: base_nxt = `VSC_BASE_0;
            5'h03: base_nxt = `VSC_BASE_1;
            5'h05: base_nxt = `VSC_BASE_2;
            5'h07: base_nxt = `VSC_BASE_3;
            5'h09: base_nxt = `VSC_BASE_4;
            5'h00: base_nxt = `VSC_BASE_5;
            5'h02: base_nxt = `VSC_BASE_6;
            5'h04: base_nxt = `VSC_BASE_7;
            5'h08: base_nxt = `VSC_BASE_8;
            5'h06: base_nxt = `VSC_BASE_9;
            5'h1A: begin
                base_nxt = `VSC_BASE_10;
                short_nxt = 1'b1;
            end
            5'h1C: begin
                base_nxt = `VSC_BASE_11;
                short_nxt = 1'b1;
            end
            default: base_ok_nxt = 1'b0;
        endcase
        irq_nxt = irq_level(strap_irq_sel);
    end

    ////////////////////////////////////////////////////////////////
    // capture once
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            cap_r <= 1'b0;
            irq_lvl_r <= `VSC_IRQ_DEFAULT;
            ack_code_r <= `VSC_IRQ_DEFAULT;
            base_r <= `VSC_BASE_5;
            short_r <= 1'b0;
            base_ok_r <= 1'b0;
            brq_lvl_r <= `VSC_BRQ_DEFAULT;
            mst_am_r <= `VSC_AM_STD;
            prn_alt_r <= 1'b0;
            baud_alt_r <= 1'b0;
            cfg_err_r <= 1'b0;
        end else if (!cap_r) begin
            cap_r <= 1'b1;
            irq_lvl_r <= irq_nxt;
            ack_code_r <= strap_ack_code;
            base_r <= base_nxt;
            short_r <= short_nxt;
            base_ok_r <= base_ok_nxt;
            brq_lvl_r <= strap_brq_sel;
            mst_am_r <= strap_am_ext ? `VSC_AM_EXT : `VSC_AM_STD;
            // both straps must agree on the second variant
            prn_alt_r <= strap_strobe_alt & strap_prn_type;
            baud_alt_r <= strap_baud_alt;
            // request and acknowledge codes must agree
            cfg_err_r <= (irq_nxt == 3'h0) || (strap_ack_code != irq_nxt) || !base_ok_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // modifier per address space
    wire am_match = short_r ? (slv_am == `VSC_AM_SHORT) : (slv_am == `VSC_AM_STD);
    wire [23:0] addr_cmp = short_r ? {8'h00, slv_addr[15:0]} : slv_addr;
    wire irq_ok = cap_r && !cfg_err_r;

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            slv_sel_r <= 1'b0;
            irq_out_r <= 7'h00;
            iack_hit_r <= 1'b0;
        end else begin
            slv_sel_r <= cap_r && base_ok_r && slv_as && am_match &&
                ((addr_cmp & `VSC_WIN_MASK) == base_r);
            // only levels 3..6 reachable; default 4
            irq_out_r <= 7'h00;
            if (irq_ok && irq_req)
                irq_out_r[irq_lvl_r] <= 1'b1;
            // level match
            // full three-bit compare: two bits cannot tell levels 1 and 5 apart
            iack_hit_r <= irq_ok && irq_req && iack_cycle && (iack_level == ack_code_r);
        end
    end

    ////////////////////////////////////////////////////////////////
    localparam ST_IDLE = 3'b001;
    localparam ST_REQ = 3'b010;
    localparam ST_OWN = 3'b100;
    reg [2:0] st_r;

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            st_r <= ST_IDLE;
            bus_req_r <= 4'h0;
            bus_owned_r <= 1'b0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (cap_r && xfer_req) begin
                        bus_req_r <= 4'h1 << brq_lvl_r;
                        st_r <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    if (bus_grant) begin
                        bus_req_r <= 4'h0;
                        bus_owned_r <= 1'b1;
                        st_r <= ST_OWN;
                    end
                end
                ST_OWN: begin
                    if (xfer_done) begin
                        bus_owned_r <= 1'b0;
                        st_r <= ST_IDLE;
                    end
                end
                default: begin
                    bus_req_r <= 4'h0;
                    bus_owned_r <= 1'b0;
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    wire [16*LINES-1:0] rate_w;
    wire [LINES-1:0] ok_w;
    genvar g;
    generate
        for (g = 0; g < LINES; g = g + 1) begin : g_line
            // lookup from the selected table only
            vsc_baud_table u_tab (
                .table_alt(baud_alt_r),
                .rate_code(line_rate_code[4*g+3:4*g]),
                .rate_baud(rate_w[16*g+15:16*g]),
                .rate_valid(ok_w[g])
            );
        end
    endgenerate

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            line_rate_r <= {16*LINES{1'b0}};
            line_rate_ok_r <= {LINES{1'b0}};
        end else begin
            line_rate_r <= rate_w;
            line_rate_ok_r <= ok_w & {LINES{cap_r}};
        end
    end
endmodule

//--- dv/vsc_arb_model.sv
// bus arbiter model for the requester side
`timescale 1ns/1ps
module vsc_arb_model (
    input wire clk_sys,
    input wire rst_b,
    input wire [3:0] bus_req_r,
    input wire [3:0] arb_dly,
    output reg bus_grant
);
    reg [3:0] wait_r;
    // grant withdrawn on the first clock edge that samples the request lines at zero
    always @(posedge clk_sys) begin
        if (!rst_b || bus_req_r == 4'h0) begin
            wait_r <= 4'h0;
            bus_grant <= 1'b0;
        end else if (wait_r == arb_dly) begin
            bus_grant <= 1'b1;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule

//--- dv/vsc_strap_cfg_sva.sv
// checker: interrupter, requester, decode and strap hold properties
`timescale 1ns/1ps
module vsc_strap_cfg_sva (
    input wire clk_sys,
    input wire rst_b,
    input wire [5:0] slv_am,
    input wire slv_as,
    input wire slv_sel_r,
    input wire irq_req,
    input wire [7:1] irq_out_r,
    input wire iack_cycle,
    input wire [2:0] iack_level,
    input wire iack_hit_r,
    input wire bus_grant,
    input wire xfer_done,
    input wire [3:0] bus_req_r,
    input wire bus_owned_r,
    input wire [5:0] mst_am_r,
    input wire prn_alt_r,
    input wire baud_alt_r
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_irq_legal: assert property (!irq_out_r[1] && !irq_out_r[2] && !irq_out_r[7])
        else $error("interrupt on unavailable level");
    a_irq_single: assert property (irq_out_r != 7'h00 |-> $onehot(irq_out_r) && $past(irq_req))
        else $error("interrupt not single or uncaused");
    a_iack_cause: assert property (iack_hit_r |-> $past(iack_cycle && irq_req))
        else $error("acknowledge answered without cause");
    a_iack_level: assert property (iack_hit_r |-> (7'h01 << ($past(iack_level) - 3'h1)) == irq_out_r)
        else $error("acknowledge on a level not requested");
    a_am_choice: assert property (mst_am_r == 6'h3D || mst_am_r == 6'h0D)
        else $error("master modifier illegal");
    a_brq_one: assert property ($onehot0(bus_req_r))
        else $error("more than one request line");
    a_grant_own: assert property (|bus_req_r && bus_grant |=> bus_owned_r)
        else $error("grant not taken");
    a_done_drop: assert property (bus_owned_r && xfer_done |=> !bus_owned_r)
        else $error("bus kept after done");
    a_sel_cause: assert property (slv_sel_r |-> $past(slv_as)
        && ($past(slv_am) == 6'h3D || $past(slv_am) == 6'h2D))
        else $error("select without valid cycle");
    a_strap_hold: assert property ($past(rst_b) && $past(rst_b, 2)
        |-> $stable(prn_alt_r) && $stable(baud_alt_r) && $stable(mst_am_r))
        else $error("strap result moved");
endmodule
bind vsc_strap_cfg vsc_strap_cfg_sva i_sva (.*);

//--- dv/vsc_strap_cfg_tb_top.sv
// testbench: strap capture, decode, interrupter, requester and baud
`timescale 1ns/1ps
module vsc_strap_cfg_tb_top;
    reg clk_sys = 0, rst_b = 0, slv_as = 0, irq_req = 0, iack_cycle = 0;
    reg strap_strobe_alt = 0, strap_prn_type = 0, strap_am_ext = 0, strap_baud_alt = 0;
    reg xfer_req = 0, xfer_done = 0;
    reg [2:0] strap_ack_code = 3'h4;
    reg [3:0] strap_irq_sel = 4'h2, arb_dly = 4'h0;
    reg [4:0] strap_addr = 5'h00;
    reg [1:0] strap_brq_sel = 2'h3;
    reg [2:0] iack_level = 3'h0;
    reg [23:0] slv_addr = 24'h000000;
    reg [5:0] slv_am = 6'h00, am;
    reg [7:0] line_rate_code = 8'h00;
    wire slv_sel_r, iack_hit_r, cfg_err_r, bus_grant, bus_owned_r, prn_alt_r, baud_alt_r;
    wire [7:1] irq_out_r;
    wire [3:0] bus_req_r;
    wire [5:0] mst_am_r;
    wire [31:0] line_rate_r;
    wire [1:0] line_rate_ok_r;
    integer num_errors = 0, cmp_count = 0, i, j, r0, r1;
    reg [4:0] ad_s [0:11] = '{5'h01, 5'h03, 5'h05, 5'h07, 5'h09, 5'h00,
        5'h02, 5'h04, 5'h08, 5'h06, 5'h1A, 5'h1C};
    reg [23:0] ad_b [0:11] = '{24'hDFF520, 24'hDFF560, 24'hDFF580, 24'hDFF5C0,
        24'hDFF620, 24'hFFF520, 24'hFFF560, 24'hFFF580, 24'hFFF5A0, 24'hFFF5C0,
        24'h00F520, 24'h00F560};
    integer b0 [0:15] = '{75, 110, 134, 150, 300, 600, 1200, 1800, 2000, 2400,
        4800, 9600, 19200, 0, 0, 0};
    integer b1 [0:15] = '{50, 110, 134, 200, 300, 600, 1050, 1200, 2400, 4800,
        7200, 9600, 0, 0, 0, 0};
    vsc_strap_cfg #(.LINES(2)) i_vsc_strap_cfg (.*);
    vsc_arb_model i_vsc_arb_model (.*);
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("Error %0t: got %h want %h", $time, seen, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            if (num_errors == 0 && cmp_count > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task wt(input integer n);
        begin
            repeat (n) @(posedge clk_sys);
            #1;
        end
    endtask
    // straps are set by the caller just before this
    task do_reset;
        begin
            rst_b <= 1'b0;
            repeat (10) @(posedge clk_sys);
            rst_b <= 1'b1;
            wt(3);
        end
    endtask
    task slv(input [23:0] a, input [5:0] m, input exp);
        begin
            @(posedge clk_sys);
            slv_addr <= a;
            slv_am <= m;
            slv_as <= 1'b1;
            wt(1);
            chk(slv_sel_r, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        r0 = $urandom(32'h2f951ec8);
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge clk_sys);
            strap_irq_sel <= 4'h1 << i;
            strap_ack_code <= 3'(i + 3);
            strap_brq_sel <= 2'(i);
            {strap_prn_type, strap_strobe_alt} <= 2'(i);
            strap_am_ext <= i[0];
            strap_baud_alt <= i[1];
            arb_dly <= 4'($urandom % 6);
            do_reset;
            chk(cfg_err_r, 0);
            chk(prn_alt_r, i == 3);
            chk(mst_am_r, i[0] ? 6'h0D : 6'h3D);
            chk(baud_alt_r, i[1]);
            @(posedge clk_sys);
            irq_req <= 1'b1;
            iack_cycle <= 1'b1;
            iack_level <= 3'(i + 3);
            wt(1);
            chk(irq_out_r, 7'h01 << (i + 2));
            chk(iack_hit_r, 1);
            @(posedge clk_sys);
            // neighbouring level must not be answered
            iack_level <= iack_level ^ 3'h1;
            wt(1);
            chk(iack_hit_r, 0);
            @(posedge clk_sys);
            irq_req <= 1'b0;
            iack_cycle <= 1'b0;
            xfer_req <= 1'b1;
            wt(1);
            for (j = 0; j < 4 && bus_req_r === 4'h0; j = j + 1) wt(1);
            chk(bus_req_r, 4'h1 << i);
            for (j = 0; j < 20 && bus_owned_r !== 1'b1; j = j + 1) wt(1);
            chk(bus_owned_r, 1);
            chk(irq_out_r, 0);
            @(posedge clk_sys);
            xfer_req <= 1'b0;
            xfer_done <= 1'b1;
            wt(1);
            chk(bus_owned_r, 0);
            for (j = 0; j < 16; j = j + 1) begin
                @(posedge clk_sys);
                xfer_done <= 1'b0;
                line_rate_code <= {4'($urandom), 4'(j)};
                wt(1);
                r0 = i[1] ? b1[j] : b0[j];
                r1 = i[1] ? b1[line_rate_code[7:4]] : b0[line_rate_code[7:4]];
                chk(line_rate_r, {16'(r1), 16'(r0)});
                chk(line_rate_ok_r, {r1 != 0, r0 != 0});
            end
        end
        for (i = 0; i < 12; i = i + 1) begin
            @(posedge clk_sys);
            strap_addr <= ad_s[i];
            do_reset;
            am = i < 10 ? 6'h3D : 6'h2D;
            j = $urandom % 32;
            slv(24'(ad_b[i] + j), am, 1);
            @(posedge clk_sys);
            slv_as <= 1'b0;
            wt(1);
            chk(slv_sel_r, 0);
            slv(24'(ad_b[i] + 32), am, 0);
            slv(24'(ad_b[i] - 1), am, 0);
            slv(24'(ad_b[i] + j), am ^ 6'h10, 0);
        end
        // straps moved while running must change nothing
        @(posedge clk_sys);
        strap_addr <= 5'h00;
        strap_am_ext <= 1'b0;
        slv(24'hA5F560, 6'h2D, 1);
        slv(24'hFFF520, 6'h3D, 0);
        chk(mst_am_r, 6'h0D);
        // bad combos: code mismatch, two request straps, unlisted address straps
        for (i = 0; i < 3; i = i + 1) begin
            @(posedge clk_sys);
            strap_irq_sel <= i == 1 ? 4'h3 : 4'h1;
            strap_ack_code <= i == 0 ? 3'h5 : 3'h3;
            strap_addr <= i == 2 ? 5'h1F : 5'h00;
            do_reset;
            chk(cfg_err_r, 1);
            @(posedge clk_sys);
            irq_req <= 1'b1;
            wt(2);
            chk(irq_out_r, 0);
            slv(24'hFFF520, 6'h3D, i != 2);
        end
        report_and_stop;
    end
    initial begin
        #100000;
        num_errors = num_errors + 1;
        report_and_stop;
    end
endmodule
